// File: service_unit_defines.svh
// Constants for the service unit access gating block
// Behaviour
// [R1] Offsets 0x100 to 0x1FFF are external; restrictions apply there.
// [R2] Offsets 0x0 to 0xFF are internal accesses.
// [R3] Protected with access level below 2: refuse external checksum requests.
// [R4] Protected with access level below 2: refuse external memory selftest requests.
// [R5] Identification, debug and boot channels stay reachable externally always.
// [R6] Error action 0 stops, 1 pauses; 2 and 3 reserved, not programmed.
// [R7] Internal accesses are never restricted by protection or access level.
`ifndef SERVICE_UNIT_DEFINES_SVH
`define SERVICE_UNIT_DEFINES_SVH
`define INT_LO 13'h0000
`define INT_HI 13'h00FF
`define EXT_LO 13'h0100
`define EXT_HI 13'h1FFF
`define LEVEL_MIN 2'h2
`define ACT_STOP 2'h0
`define ACT_PAUSE 2'h1
`define ACT_RESET 2'h0
`endif

// File: service_unit_pkg.sv
// Types for the service unit access gating block
package service_unit_pkg;
    typedef enum logic [1:0] {
        SVC_CHECKSUM = 2'b00,
        SVC_SELFTEST = 2'b01,
        SVC_IDENT = 2'b10,
        SVC_CHANNEL = 2'b11
    } service_e;
    typedef enum logic [1:0] {
        RANGE_INTERNAL = 2'b00,
        RANGE_EXTERNAL = 2'b01,
        RANGE_NONE = 2'b10
    } range_e;
endpackage

// File: range_classifier.sv
// Offset classifier into internal, external or unmapped range
`timescale 1ns/1ps
`include "service_unit_defines.svh"
module range_classifier
    import service_unit_pkg::*;
(
    // Offset in
    input wire logic [12:0] i_offset,
    // Class out
    output range_e o_range
);
    // Range decode
    always_comb
    begin
        if (i_offset <= `INT_HI)
            o_range = RANGE_INTERNAL; // [R2]
        else if (i_offset >= `EXT_LO && i_offset <= `EXT_HI)
            o_range = RANGE_EXTERNAL; // [R1]
        else
            o_range = RANGE_NONE;
    end
endmodule

// File: service_unit_gate.sv
// Access gating top of the service unit
`timescale 1ns/1ps
`include "service_unit_defines.svh"
module service_unit_gate
    import service_unit_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // Access request
    input wire logic i_req,
    input wire logic [12:0] i_offset,
    input wire logic [1:0] i_service,
    // Protection state
    input wire logic i_protected,
    input wire logic [1:0] i_debug_access_level,
    // Self test error action setting
    input wire logic i_action_we,
    input wire logic [1:0] i_action_wdata,
    // Answer
    output logic o_grant,
    output logic o_refuse,
    output logic o_external,
    output logic [1:0] o_selftest_error_action
);

    // ----------------------------------------
    // Internal signals
    // ----------------------------------------
    // Range of the current offset
    range_e cls;
    // Requested service as its enum
    service_e svc;
    // External range while protected below the open access level
    logic restricted;
    // Service permitted for this range and protection state
    logic allow;
    // Request falls in a mapped range and is permitted
    logic accept;
    // High once an edge has sampled reset released
    logic settled;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    // True for a range that maps onto a service unit access;
    // an unmapped offset is refused whatever the service
    function automatic logic range_mapped(range_e r);
        return (r == RANGE_INTERNAL) || (r == RANGE_EXTERNAL);
    endfunction

    // True for the services that protection may withhold:
    // checksum and memory selftest, never identification or channels
    function automatic logic service_gated(service_e s);
        return (s == SVC_CHECKSUM) || (s == SVC_SELFTEST);
    endfunction

    // True for an error action code that hardware may store
    function automatic logic action_legal(logic [1:0] code);
        return (code == `ACT_STOP) || (code == `ACT_PAUSE);
    endfunction

    // ----------------------------------------
    // Range classification
    // ----------------------------------------
    // Service code taken as its enum
    assign svc = service_e'(i_service);

    // Offset classification into internal, external or unmapped;
    // the unmapped class cannot arise with thirteen offset bits
    range_classifier u_cls
    (
        .i_offset(i_offset),
        .o_range(cls)
    );

    // ----------------------------------------
    // Gating decision
    // ----------------------------------------
    // Restriction applies only externally when protected at low level;
    // internal accesses never see it, whatever the protection state
    assign restricted = (cls == RANGE_EXTERNAL) && i_protected
        && (i_debug_access_level < `LEVEL_MIN); // [R3] [R4] [R7]

    // Service permission; identification and channels stay open
    // even while protected, so a locked part can still be identified
    always_comb
    begin
        if (service_gated(svc))
            allow = !restricted; // [R3] [R4] [R7]
        else
            allow = 1'b1; // [R5]
    end

    // Mapped and permitted requests are granted, all others refused
    assign accept = range_mapped(cls) && allow; // [R1] [R2]

    // ----------------------------------------
    // Registered answers, one cycle after the request
    // ----------------------------------------
    // Each answer stands one cycle; back to back requests give back
    // to back answers, with no state carried between them
    // All three answers clear while reset is held
    // Grant pulse for an accepted request
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
            o_grant <= 1'b0;
        else
            o_grant <= i_req && accept; // [R5] [R7]
    end

    // Refuse pulse for a withheld or unmapped request
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
            o_refuse <= 1'b0;
        else
            o_refuse <= i_req && !accept; // [R3] [R4]
    end

    // External flag, set for requests in the external range
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
            o_external <= 1'b0;
        else
            o_external <= i_req && (cls == RANGE_EXTERNAL); // [R1]
    end

    // ----------------------------------------
    // Self test error action
    // ----------------------------------------
    // Reserved codes are ignored and the old value is kept, so a stray
    // write cannot leave the self test in an undefined error mode
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
            o_selftest_error_action <= `ACT_RESET;
        else if (i_action_we && action_legal(i_action_wdata))
            o_selftest_error_action <= i_action_wdata; // [R6]
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Reset state as the checks see it; a one-cycle reset pulse applied
    // at an edge would otherwise escape the disable condition
    always_ff @(posedge i_clock)
    begin
        settled <= i_rstn;
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn || !settled);

    // Protected external checksum and selftest requests below access level 2 are refused
    a_ext_checksum_refused: assert property ( // [R3]
        i_req && i_offset >= 13'h0100 && i_protected
        && i_debug_access_level < 2'h2 && i_service == 2'h0
        |=> o_refuse && !o_grant)
        else $error("external checksum not refused");
    a_ext_selftest_refused: assert property ( // [R4]
        i_req && i_offset >= 13'h0100 && i_protected
        && i_debug_access_level < 2'h2 && i_service == 2'h1
        |=> o_refuse && !o_grant)
        else $error("external selftest not refused");

    // Open services and internal accesses are always granted
    a_open_services_granted: assert property ( // [R5]
        i_req && i_service[1] |=> o_grant)
        else $error("open service not granted");
    a_internal_unrestricted: assert property ( // [R7]
        i_req && i_offset <= 13'h00FF |=> o_grant && !o_external)
        else $error("internal access refused");

    // Range flag follows the offset of each request
    a_external_flagged: assert property ( // [R1]
        i_req && i_offset >= 13'h0100 |=> o_external)
        else $error("external access not flagged");
    a_internal_class: assert property ( // [R2]
        i_req && i_offset < 13'h0100 |=> !o_external)
        else $error("internal access flagged external");

    // A high access level or no protection lifts the restriction,
    // and nothing else refuses a mapped request
    a_high_level_open: assert property ( // [R3]
        i_req && i_debug_access_level >= 2'h2 |=> o_grant)
        else $error("full access level refused");
    a_unprotected_open: assert property ( // [R7]
        i_req && !i_protected |=> o_grant)
        else $error("unprotected access refused");
    a_refuse_cause: assert property ( // [R7]
        i_req && !(i_offset >= 13'h0100 && i_protected
        && i_debug_access_level < 2'h2 && !i_service[1])
        |=> !o_refuse)
        else $error("request refused without cause");

    // Exactly one answer per request, and none without one
    a_answer_one_hot: assert property ( // [R1]
        i_req |=> o_grant != o_refuse)
        else $error("request without exactly one answer");
    a_idle_no_answer: assert property ( // [R1]
        !i_req |=> !o_grant && !o_refuse && !o_external)
        else $error("answer without request");

    // Error action stays legal, follows legal writes, holds otherwise
    a_action_legal: assert property ( // [R6]
        o_selftest_error_action[1] == 1'b0)
        else $error("reserved error action stored");
    a_action_written: assert property ( // [R6]
        i_action_we && !i_action_wdata[1]
        |=> o_selftest_error_action == $past(i_action_wdata))
        else $error("legal action write not stored");
    a_action_hold: assert property ( // [R6]
        !(i_action_we && action_legal(i_action_wdata))
        |=> $stable(o_selftest_error_action))
        else $error("action changed without a legal write");

    // Main scenarios: refusals, grants on both ranges, pause setting,
    // and a refused external selftest
    c_ext_refuse: cover property (i_req ##1 o_refuse && o_external);
    c_ext_grant: cover property (i_req ##1 o_grant && o_external);
    c_int_grant: cover property (i_req ##1 o_grant && !o_external);
    c_pause_set: cover property (o_selftest_error_action == 2'h1);
    c_sel_refuse: cover property (i_req && i_service == 2'h1 ##1 o_refuse);
endmodule

// File: debug_probe_model.sv
// External debugger probe model issuing service unit requests
`timescale 1ns/1ps
module debug_probe_model
(
    // Clock and enable
    input wire logic i_clock,
    input wire logic i_run,
    // Requests toward the service unit
    output logic o_req = 1'b0,
    output logic [12:0] o_offset = 13'h0000,
    output logic [1:0] o_service = 2'h0
);
    logic [12:0] edges [4] = '{13'h00FF, 13'h0100, 13'h1FFF, 13'h0000};
    int n = 0;
    // Random traffic with range boundary offsets every fourth cycle
    always @(posedge i_clock)
    begin
        n <= n + 1;
        o_req <= i_run && ($urandom % 4 != 0);
        o_service <= 2'($urandom);
        o_offset <= (n % 4 == 0) ? edges[(n / 4) % 4] : 13'($urandom);
    end
endmodule

// File: service_unit_access_gating_test.sv
// Self-checking bench for the service unit access gating
`timescale 1ns/1ps
module service_unit_access_gating_test;
    logic clk = 0, rstn = 0, run = 0, prot = 0, we = 0, req;
    logic grant, refuse, ext, e_ref, p_rst = 0, p_req = 0, p_prot = 0;
    logic [12:0] off, p_off = 0;
    logic [1:0] svc, action, p_svc = 0, lvl = 0, p_lvl = 0, wd = 0, act = 0;
    int miscompares = 0, cmp_count = 0, cycles = 0;
    initial forever #5 clk = ~clk;
    debug_probe_model probe_u (.i_clock(clk), .i_run(run), .o_req(req),
        .o_offset(off), .o_service(svc));
    service_unit_gate dut_u (.i_clock(clk), .i_rstn(rstn), .i_req(req),
        .i_offset(off), .i_service(svc), .i_protected(prot),
        .i_debug_access_level(lvl), .i_action_we(we),
        .i_action_wdata(wd), .o_grant(grant), .o_refuse(refuse),
        .o_external(ext), .o_selftest_error_action(action));
    // Expected refusal of a request
    function automatic logic refused(logic [12:0] o, logic [1:0] s,
        logic p, logic [1:0] l);
        return o > 13'h00FF && p && l < 2'h2 && s < 2'h2;
    endfunction
    task automatic check(string name, logic [1:0] seen, logic [1:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Capture inputs of each edge, model the action setting, timeout
    always @(posedge clk)
    begin
        {p_rst, p_req, p_off, p_svc, p_prot, p_lvl} <=
            {rstn, req, off, svc, prot, lvl};
        if (!rstn)
            act <= 2'h0;
        else if (we)
            act <= wd;
        cycles <= cycles + 1;
        if (cycles == 10000)
        begin
            miscompares++;
            report_and_stop;
        end
    end
    // Compare answers one cycle after each request
    always @(negedge clk)
    begin
        e_ref = refused(p_off, p_svc, p_prot, p_lvl);
        check("grant", grant, p_rst && p_req && !e_ref);
        check("refuse", refuse, p_rst && p_req && e_ref);
        check("external", ext, p_rst && p_req && p_off > 13'h00FF);
        check("action", action, act);
    end
    // Random protection and action writes, with a reset in mid-run
    initial
    begin
        void'($urandom(2050));
        repeat (20) @(posedge clk);
        rstn <= 1;
        run <= 1;
        for (int i = 0; i < 4000; i++)
        begin
            @(posedge clk);
            rstn <= (i != 2000);
            prot <= (i < 100) ? 1'b1 : 1'($urandom);
            lvl <= (i < 100) ? 2'(i % 4) : 2'($urandom);
            we <= 1'($urandom);
            wd <= 2'($urandom % 2);
        end
        report_and_stop;
    end
endmodule
